//--- core/svwr_pkg.sv
package svwr_pkg;

  // Timing, all figures typical
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned RST_HOLD_US      = 200;
  localparam int unsigned RST_HOLD_CYC     =
    (RST_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WD_PRESET_US     = 1600;
  localparam int unsigned WD_PRESET_CYC    =
    (WD_PRESET_US * 1000) / CLK_PERIOD_NS;
  // Capacitor timeout span, standard and extended variants
  localparam int unsigned WD_STD_MIN_US    = 613;
  localparam int unsigned WD_STD_MAX_MS    = 3330;
  localparam int unsigned WD_EXT_MIN_US    = 58830;
  localparam int unsigned WD_EXT_MAX_MS    = 78350;
  localparam int unsigned WD_STD_MIN_CYC   =
    (WD_STD_MIN_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WD_STD_MAX_CYC   =
    32'((64'(WD_STD_MAX_MS) * 64'd1000000) / 64'(CLK_PERIOD_NS));
  localparam int unsigned WD_EXT_MIN_CYC   =
    (WD_EXT_MIN_US * 1000) / CLK_PERIOD_NS;
  localparam longint unsigned WD_EXT_MAX_CYC =
    (64'(WD_EXT_MAX_MS) * 64'd1000000) / 64'(CLK_PERIOD_NS);

  localparam int unsigned CNT_W            = 32;
  localparam int unsigned SYNC_STAGES      = 3;

  // Reset values of synchronised pins: high (released) or low
  localparam logic [2:0]  SYNC_RST_HI      = 3'h7;
  localparam logic [2:0]  SYNC_RST_LO      = 3'h0;

  typedef enum logic [1:0] {
    SVWR_RESET = 2'b00,
    SVWR_RUN   = 2'b01,
    SVWR_FAULT = 2'b10
  } svwr_state_t;

endpackage

//--- core/svwr_top.sv
`timescale 1ns/1ns
module svwr_top #(
  parameter logic [31:0] RST_HOLD_CYC_P  = svwr_pkg::RST_HOLD_CYC,
  parameter logic [31:0] WD_PRESET_CYC_P = svwr_pkg::WD_PRESET_CYC,
  // Capacitor span; the extended variant takes the WD_EXT bounds
  parameter logic [31:0] CAP_MIN_CYC_P   = svwr_pkg::WD_STD_MIN_CYC,
  parameter logic [31:0] CAP_MAX_CYC_P   = svwr_pkg::WD_STD_MAX_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // Pins
  input  wire logic        manual_reset_in_n_i,
  input  wire logic        supply_good_i,
  input  wire logic        wd_enable_strap_i,
  input  wire logic        watchdog_kick_in_i,
  // Timing pin: capacitor fitted, and its programmed count
  input  wire logic        timeout_timing_pin_cap_i,
  input  wire logic [31:0] cap_timeout_cyc_i,
  // Open-drain outputs, enable low while driving low
  output logic             supervisor_reset_out_o,
  output logic             supervisor_reset_out_oe_n_o,
  output logic             watchdog_fault_out_o,
  output logic             watchdog_fault_out_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three stages, change when stages two and three agree
  logic [2:0] mr_sync_r;
  logic [2:0] pg_sync_r;
  logic [2:0] en_sync_r;
  logic [2:0] kick_sync_r;
  logic [2:0] cap_sync_r;
  logic       mr_n_r;
  logic       pg_r;
  logic       en_r;
  logic       kick_r;
  logic       cap_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mr_sync_r   <= svwr_pkg::SYNC_RST_HI;
      pg_sync_r   <= svwr_pkg::SYNC_RST_LO;
      en_sync_r   <= svwr_pkg::SYNC_RST_LO;
      kick_sync_r <= svwr_pkg::SYNC_RST_HI;
      cap_sync_r  <= svwr_pkg::SYNC_RST_LO;
    end else begin
      mr_sync_r   <= {mr_sync_r[1:0], manual_reset_in_n_i};
      pg_sync_r   <= {pg_sync_r[1:0], supply_good_i};
      en_sync_r   <= {en_sync_r[1:0], wd_enable_strap_i};
      kick_sync_r <= {kick_sync_r[1:0], watchdog_kick_in_i};
      cap_sync_r  <= {cap_sync_r[1:0], timeout_timing_pin_cap_i};
    end
  end

  wire mr_agree   = mr_sync_r[1] == mr_sync_r[2];
  wire pg_agree   = pg_sync_r[1] == pg_sync_r[2];
  wire en_agree   = en_sync_r[1] == en_sync_r[2];
  wire kick_agree = kick_sync_r[1] == kick_sync_r[2];
  wire cap_agree  = cap_sync_r[1] == cap_sync_r[2];

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mr_n_r <= 1'b1;
      pg_r   <= 1'b0;
      en_r   <= 1'b0;
      kick_r <= 1'b1;
      cap_r  <= 1'b0;
    end else begin
      if (mr_agree)   mr_n_r <= mr_sync_r[2];
      if (pg_agree)   pg_r   <= pg_sync_r[2];
      if (en_agree)   en_r   <= en_sync_r[2];
      if (kick_agree) kick_r <= kick_sync_r[2];
      if (cap_agree)  cap_r  <= cap_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  svwr_pkg::svwr_state_t state_r;
  svwr_pkg::svwr_state_t state_nxt;
  logic [31:0]           hold_cnt_r;
  logic [31:0]           hold_cnt_nxt;
  logic [31:0]           wd_cnt_r;
  logic [31:0]           wd_cnt_nxt;
  logic                  kick_d_r;

  // Any reset cause; supply loss covers power-up as well
  wire reset_cause = !mr_n_r || !pg_r;
  wire in_reset    = state_r == svwr_pkg::SVWR_RESET;
  wire in_fault    = state_r == svwr_pkg::SVWR_FAULT;
  wire wd_on       = en_r;
  // Only kicks while running and enabled count
  wire kick_fall   = kick_d_r && !kick_r;
  wire kick_ok     = kick_fall && wd_on && !in_reset && !in_fault;
  // Count pinned to the span, so a bad capacitor never stops the watchdog
  wire        cap_lo   = cap_timeout_cyc_i < CAP_MIN_CYC_P;
  wire        cap_hi   = cap_timeout_cyc_i > CAP_MAX_CYC_P;
  wire [31:0] cap_cyc  = cap_lo ? CAP_MIN_CYC_P
                       : cap_hi ? CAP_MAX_CYC_P
                       : cap_timeout_cyc_i;
  wire [31:0] wd_limit = cap_r ? cap_cyc : WD_PRESET_CYC_P;
  wire hold_done   = hold_cnt_r >= RST_HOLD_CYC_P - 32'h1;
  wire wd_expire   = wd_on && (wd_cnt_r >= wd_limit - 32'h1);

  always_comb begin
    state_nxt    = state_r;
    hold_cnt_nxt = hold_cnt_r;
    wd_cnt_nxt   = wd_cnt_r;
    unique case (state_r)
      svwr_pkg::SVWR_RESET: begin
        wd_cnt_nxt = 32'h0;
        if (reset_cause) begin
          hold_cnt_nxt = 32'h0;
        end else if (hold_done) begin
          state_nxt    = svwr_pkg::SVWR_RUN;
          hold_cnt_nxt = 32'h0;
        end else begin
          hold_cnt_nxt = hold_cnt_r + 32'h1;
        end
      end
      svwr_pkg::SVWR_RUN: begin
        hold_cnt_nxt = 32'h0;
        if (reset_cause) begin
          state_nxt  = svwr_pkg::SVWR_RESET;
        end else if (kick_ok || !wd_on) begin
          wd_cnt_nxt = 32'h0;
        end else if (wd_expire) begin
          state_nxt  = svwr_pkg::SVWR_FAULT;
          wd_cnt_nxt = 32'h0;
        end else begin
          wd_cnt_nxt = wd_cnt_r + 32'h1;
        end
      end
      svwr_pkg::SVWR_FAULT: begin
        wd_cnt_nxt = 32'h0;
        if (reset_cause) begin
          state_nxt    = svwr_pkg::SVWR_RESET;
          hold_cnt_nxt = 32'h0;
        end else if (hold_done) begin
          state_nxt    = svwr_pkg::SVWR_RUN;
          hold_cnt_nxt = 32'h0;
        end else begin
          hold_cnt_nxt = hold_cnt_r + 32'h1;
        end
      end
      default: begin
        state_nxt    = svwr_pkg::SVWR_RESET;
        hold_cnt_nxt = 32'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r    <= svwr_pkg::SVWR_RESET;
      hold_cnt_r <= 32'h0;
      wd_cnt_r   <= 32'h0;
      kick_d_r   <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      wd_cnt_r   <= wd_cnt_nxt;
      kick_d_r   <= kick_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, registered; open drain only ever pulls low
  logic rst_low_r;
  logic wdo_low_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_low_r <= 1'b1;
      wdo_low_r <= 1'b0;
    end else begin
      rst_low_r <= state_nxt == svwr_pkg::SVWR_RESET;
      wdo_low_r <= state_nxt == svwr_pkg::SVWR_FAULT;
    end
  end

  assign supervisor_reset_out_o      = 1'b0;
  assign supervisor_reset_out_oe_n_o = !rst_low_r;
  assign watchdog_fault_out_o        = 1'b0;
  assign watchdog_fault_out_oe_n_o   = !wdo_low_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence manual_held_s;
    !mr_n_r;
  endsequence

  reset_follows_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    manual_held_s |=> rst_low_r)
    else $error("reset not asserted under manual reset");

  undervolt_reset_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !pg_r |=> rst_low_r)
    else $error("reset not asserted on undervoltage");

  hold_after_mr_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(rst_low_r == 1'b0) |-> $past(hold_cnt_r) == RST_HOLD_CYC_P - 1)
    else $error("reset released before hold time");

  fault_excl_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !(rst_low_r && wdo_low_r))
    else $error("fault and reset low together");

  fault_release_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(rst_low_r) |-> watchdog_fault_out_oe_n_o)
    else $error("fault not released on reset");

  disabled_quiet_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !en_r && !in_fault |=> !wdo_low_r)
    else $error("fault while watchdog disabled");

  kick_ignored_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (in_reset || in_fault) |=> wd_cnt_r == 32'h0)
    else $error("watchdog counted in reset or fault");

  kick_restart_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    kick_ok && !reset_cause |=> wd_cnt_r == 32'h0 && !wdo_low_r)
    else $error("kick did not restart count");

  timeout_fault_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    state_r == svwr_pkg::SVWR_RUN && wd_expire && !kick_ok && !reset_cause
    |=> wdo_low_r)
    else $error("timeout did not assert fault");

  // Filters: a pin level moves only once two stages agree
  mr_filter_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !mr_agree |=> $stable(mr_n_r))
    else $error("manual reset changed before stages agreed");

  pg_filter_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !pg_agree |=> $stable(pg_r))
    else $error("supply good changed before stages agreed");

  kick_filter_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !kick_agree |=> $stable(kick_r))
    else $error("kick level changed before stages agreed");

  // Release steps: causes gone, then the full hold count
  sequence reset_end_s;
    $fell(rst_low_r);
  endsequence

  sequence fault_end_s;
    $fell(wdo_low_r) && !rst_low_r;
  endsequence

  release_clean_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    reset_end_s |-> $past(pg_r) && $past(mr_n_r))
    else $error("reset released with a cause present");

  fault_len_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    fault_end_s |-> $past(hold_cnt_r) == RST_HOLD_CYC_P - 32'h1)
    else $error("fault pulse shorter than hold time");

  wd_off_idle_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    state_r == svwr_pkg::SVWR_RUN && !wd_on |=> wd_cnt_r == 32'h0)
    else $error("watchdog counted while disabled");

  cap_span_a: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    cap_r |-> wd_limit >= CAP_MIN_CYC_P && wd_limit <= CAP_MAX_CYC_P)
    else $error("capacitor timeout outside its span");

endmodule

//--- test/svwr_proc_model.sv
`timescale 1ns/1ns
module svwr_proc_model (
  // Clock
  input  wire logic        core_clk_i,
  // Control from the bench
  input  wire logic        kick_en_i,
  input  wire logic [31:0] half_period_i,
  // Kick pin, never left floating
  output logic             watchdog_kick_in_o
);
  logic [31:0] cnt_r;
  logic        en_q;

  initial begin
    cnt_r = 32'h0;
    en_q = 1'b0;
    watchdog_kick_in_o = 1'b1; // Defined level while idle
  end

  // Toggles only when asked, so a silent processor is modelled too
  always @(posedge core_clk_i) begin
    // Taken at the edge, clear of the bench's own update after it
    en_q = kick_en_i;
    #2;
    if (!en_q) begin
      cnt_r = 32'h0;
    end else if (cnt_r == half_period_i - 32'h1) begin // Toggle, rising or falling edge
      cnt_r = 32'h0;
      watchdog_kick_in_o = ~watchdog_kick_in_o;
    end else begin
      cnt_r = cnt_r + 32'h1;
    end
  end
endmodule

//--- test/svwr_top_tb_top.sv
`timescale 1ns/1ns
module svwr_top_tb_top;
  localparam int HOLD = 20;
  localparam int PRESET = 50;
  localparam int CAPC = 30;
  localparam int CAPMIN = 25;
  localparam int CAPMAX = 40;
  logic [31:0] cap_cyc = 32'(CAPC);
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        mr_n = 1'b1;
  logic        sup_ok = 1'b0;
  logic        strap = 1'b0;
  logic        cap_sel = 1'b0;
  logic        kick_en = 1'b0;
  logic        kick;
  logic        rst_d;
  logic        rst_oe_n;
  logic        flt_d;
  logic        flt_oe_n;
  int          mismatches = 0;
  int          total_checks = 0;
  int          n;
  // Open-drain lines with pull-ups
  wire         rst_line = rst_oe_n ? 1'b1 : rst_d;
  wire         flt_line = flt_oe_n ? 1'b1 : flt_d;

  always #20 clk = ~clk;

  svwr_top #(
    .RST_HOLD_CYC_P  (32'(HOLD)),
    .WD_PRESET_CYC_P (32'(PRESET)),
    .CAP_MIN_CYC_P   (32'(CAPMIN)),
    .CAP_MAX_CYC_P   (32'(CAPMAX))
  ) uut (
    .core_clk_i                  (clk),
    .arst_n_i                    (arst_n),
    .manual_reset_in_n_i         (mr_n),
    .supply_good_i               (sup_ok),
    .wd_enable_strap_i           (strap),
    .watchdog_kick_in_i          (kick),
    .timeout_timing_pin_cap_i    (cap_sel),
    .cap_timeout_cyc_i           (cap_cyc),
    .supervisor_reset_out_o      (rst_d),
    .supervisor_reset_out_oe_n_o (rst_oe_n),
    .watchdog_fault_out_o        (flt_d),
    .watchdog_fault_out_oe_n_o   (flt_oe_n)
  );

  svwr_proc_model proc (
    .core_clk_i         (clk),
    .kick_en_i          (kick_en),
    .half_period_i      (32'h0000000A),
    .watchdog_kick_in_o (kick)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_bit(string what, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %b seen %b", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic chk_range(string what, int lo, int hi, int got);
    total_checks++;
    if (got < lo || got > hi) begin
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
      mismatches++;
    end
  endtask

  // Same offset after the edge for driving and sampling
  task automatic cyc();
    @(posedge clk);
    #2;
  endtask

  task automatic wait_lvl(logic is_flt, logic lvl, int lim, output int cnt);
    cnt = 0;
    while (((is_flt ? flt_line : rst_line) !== lvl) && cnt < lim) begin
      cyc();
      cnt++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    repeat (30) cyc();
    chk_bit("reset before supply good", 1'b0, rst_line);
    chk_bit("fault during reset", 1'b1, flt_line);
    sup_ok = 1'b1;
    wait_lvl(1'b0, 1'b1, 60, n);
    chk_range("power-up release", HOLD, HOLD + 8, n);
  endtask

  task automatic t_manual();
    mr_n = 1'b0;
    wait_lvl(1'b0, 1'b0, 10, n);
    chk_range("manual assert", 1, 6, n);
    repeat (10) cyc();
    chk_bit("fault in manual reset", 1'b1, flt_line);
    mr_n = 1'b1;
    wait_lvl(1'b0, 1'b1, 60, n);
    chk_range("manual release", HOLD, HOLD + 8, n);
  endtask

  task automatic t_disabled();
    int lows;
    lows = 0;
    kick_en = 1'b1;
    repeat (25) cyc();
    kick_en = 1'b0;
    repeat (150) begin
      cyc();
      if (flt_line !== 1'b1) lows++;
    end
    chk_range("fault cycles disabled", 0, 0, lows);
  endtask

  task automatic t_preset();
    strap = 1'b1;
    wait_lvl(1'b1, 1'b0, PRESET + 20, n);
    chk_range("preset timeout", PRESET - 1, PRESET + 8, n);
    chk_bit("reset at timeout", 1'b1, rst_line);
    wait_lvl(1'b1, 1'b1, HOLD + 10, n);
    chk_range("fault pulse", HOLD - 1, HOLD + 2, n);
    wait_lvl(1'b1, 1'b0, PRESET + 20, n);
    chk_range("restart after fault", PRESET - 1, PRESET + 8, n);
    cap_sel = 1'b1;
  endtask

  task automatic t_cap_kick();
    int lows;
    lows = 0;
    wait_lvl(1'b1, 1'b1, HOLD + 10, n);
    chk_range("fault pulse preset", HOLD - 1, HOLD + 2, n);
    wait_lvl(1'b1, 1'b0, PRESET + 20, n);
    chk_range("capacitor timeout", CAPC - 1, CAPC + 8, n);
    wait_lvl(1'b1, 1'b1, HOLD + 10, n);
    chk_range("fault pulse capacitor", HOLD - 1, HOLD + 2, n);
    kick_en = 1'b1;
    repeat (200) begin
      cyc();
      if (flt_line !== 1'b1) lows++;
    end
    chk_range("fault cycles kicked", 0, 0, lows);
    kick_en = 1'b0;
    wait_lvl(1'b1, 1'b0, PRESET + 20, n);
    chk_range("timeout after kicks stop", 1, CAPC + 8, n);
  endtask

  task automatic t_cap_span();
    cap_cyc = 32'h00000005;
    wait_lvl(1'b1, 1'b1, HOLD + 10, n);
    chk_range("fault pulse short cap", HOLD - 1, HOLD + 2, n);
    wait_lvl(1'b1, 1'b0, PRESET + 20, n);
    chk_range("short cap timeout", CAPMIN - 1, CAPMIN + 2, n);
    cap_cyc = 32'h000001F4;
    wait_lvl(1'b1, 1'b1, HOLD + 10, n);
    chk_range("fault pulse long cap", HOLD - 1, HOLD + 2, n);
    wait_lvl(1'b1, 1'b0, PRESET + 20, n);
    chk_range("long cap timeout", CAPMAX - 1, CAPMAX + 2, n);
  endtask

  task automatic t_undervolt();
    sup_ok = 1'b0;
    wait_lvl(1'b0, 1'b0, 10, n);
    chk_range("undervoltage assert", 1, 6, n);
    repeat (2) cyc();
    chk_bit("fault released by reset", 1'b1, flt_line);
    sup_ok = 1'b1;
    wait_lvl(1'b0, 1'b1, 60, n);
    chk_range("supply good release", HOLD, HOLD + 8, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    #2;
    arst_n = 1'b1;
    t_power_up();
    t_manual();
    t_disabled();
    t_preset();
    t_cap_kick();
    t_cap_span();
    t_undervolt();
    end_of_test();
  end

  // Whole run needs about 850 cycles; this is a generous ceiling
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule
